// File: shared/sar_consts.svh
// constants and summary of operation for the serial sar converter readout
// Summary of operation
// [R1] a falling edge of the active-low frame select starts a new conversion
// [R2] the host keeps frame select low for the whole conversion and readout frame
// [R3] while frame select is high the converter only samples, never converts
// [R4] a frame is two null bits then fourteen result bits, most significant first
// [R5] output changes on falling shift-clock edges; host captures on the next rising edge
// [R6] approximation steps advance on the host shift clock, no internal conversion clock
// [R7] result is unsigned straight binary, zero at lowest input, all ones at full scale
// [R8] bits shifted out belong to the conversion running in the same frame
// [R9] serial output is released to high impedance while frame select is high
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define SAR_RES_BITS   14
`define SAR_NULL_BITS  2
`define SAR_FRAME_BITS 16
`define SAR_CNT_W      5
`define SAR_FIFO_W     14
`define SAR_FIFO_DEPTH 32
`define SAR_FIFO_AW    5
`endif

// File: shared/sar_pkg.sv
// types for the serial sar converter readout
package sar_pkg;
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_NULL   = 3'b010,
    ST_DATA   = 3'b100
  } frame_state_t;
endpackage

// File: verilog/sar_adc_serial_readout.sv
// serial conversion and readout logic of a 14-bit sar converter, with sample fifo
`timescale 1ns/1ns
`include "sar_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter int WIDTH = `SAR_FIFO_W,
  parameter int DEPTH = `SAR_FIFO_DEPTH,
  parameter int AW    = `SAR_FIFO_AW
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             reset_i,   // async reset, active high
  input  wire logic             ce_i,      // clock enable
  input  wire logic [WIDTH-1:0] in_data_i, // word to store
  input  wire logic             in_valid_i,// word offered
  output logic                  in_ready_o,// room available
  output logic      [WIDTH-1:0] out_data_o,// head word
  output logic                  out_valid_o,// head valid
  input  wire logic             out_ready_i // consumer takes head
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sar_adc_serial_readout
  import sar_pkg::*;
(
  input  wire logic                     clk_i,         // 125 mhz system clock
  input  wire logic                     reset_i,       // async reset, active high
  input  wire logic                     ce_i,          // clock enable, freezes all state
  input  wire logic                     sel_n_i,       // frame select pin, active low
  input  wire logic                     sclk_i,        // host shift clock pin
  input  wire logic                     cmp_i,         // comparator: input above trial level
  output logic      [`SAR_RES_BITS-1:0] trial_o,       // trial code to the dac
  output logic                          track_o,       // sample switch closed
  output logic                          sdo_o,         // serial data out
  output logic                          sdo_oe_o,      // serial data output enable
  output logic      [`SAR_RES_BITS-1:0] sample_data_o, // fifo head: finished result
  output logic                          sample_valid_o,// fifo head valid
  input  wire logic                     sample_ready_i,// consumer takes a result
  output logic                          overrun_o      // result dropped, fifo full
);
  logic [2:0] sel_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic       sel_fall;
  logic       sclk_fall;
  logic       sclk_rise;
  frame_state_t                state_reg;
  logic [`SAR_CNT_W-1:0]       bit_reg;
  logic [`SAR_RES_BITS-1:0]    res_reg;
  logic [`SAR_RES_BITS-1:0]    trial_reg;
  logic [`SAR_RES_BITS-1:0]    mask_reg;
  logic                        sdo_reg;
  logic                        oe_reg;
  logic                        push_reg;
  logic                        ovr_reg;
  logic [`SAR_RES_BITS-1:0]    fifo_dout;
  logic                        fifo_valid;
  logic                        fifo_ready;
  logic [`SAR_RES_BITS-1:0]    head_reg;
  logic                        head_vld_reg;
  logic                        fifo_pop;

  // stage 0 is only read by stage 1; edges come from stages 1 and 2
  // each chain resets to its pin's idle level so no false edge follows reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_sync_reg  <= 3'h7;
      sclk_sync_reg <= 3'h0;
    end else if (ce_i) begin
      sel_sync_reg  <= {sel_sync_reg[1:0], sel_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
    end
  end

  assign sel_fall  = sel_sync_reg[2] && !sel_sync_reg[1];          // [R1]
  assign sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1];
  assign sclk_rise = !sclk_sync_reg[2] && sclk_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencer; a raised select aborts any frame, so the host must hold it low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_SAMPLE;
      bit_reg   <= '0;
    end else if (ce_i) begin
      if (sel_sync_reg[1]) begin
        state_reg <= ST_SAMPLE;                                      // [R3] [R2]
        bit_reg   <= '0;
      end else begin
        case (state_reg)
          ST_SAMPLE: begin
            if (sel_fall) begin
              state_reg <= ST_NULL;                                  // [R1]
              bit_reg   <= '0;
            end
          end
          ST_NULL: begin
            if (sclk_fall) begin
              bit_reg <= bit_reg + 1'b1;
              if (bit_reg == `SAR_CNT_W'(`SAR_NULL_BITS - 1)) begin
                state_reg <= ST_DATA;                                // [R4]
              end
            end
          end
          ST_DATA: begin
            if (sclk_fall && bit_reg != `SAR_CNT_W'(`SAR_FRAME_BITS)) begin
              bit_reg <= bit_reg + 1'b1;
            end
          end
          default: begin
            state_reg <= ST_SAMPLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // approximation: from the second falling shift edge of the frame, each falling edge decides one bit until all 14 are decided
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      res_reg   <= '0;
      mask_reg  <= '0;
      trial_reg <= '0;
    end else if (ce_i) begin
      if (state_reg == ST_SAMPLE) begin
        res_reg   <= '0;
        mask_reg  <= {1'b1, {(`SAR_RES_BITS-1){1'b0}}};
        trial_reg <= {1'b1, {(`SAR_RES_BITS-1){1'b0}}};
      end else if (sclk_fall && mask_reg != '0 &&
                   (state_reg == ST_DATA ||
                    bit_reg == `SAR_CNT_W'(`SAR_NULL_BITS - 1))) begin
        // keep the trial bit when the input is above the trial level [R6] [R7]
        res_reg   <= cmp_i ? (res_reg | mask_reg) : res_reg;
        trial_reg <= (cmp_i ? trial_reg : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
        mask_reg  <= mask_reg >> 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial out: the decided bit goes out the same falling edge it is decided [R8]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (ce_i) begin
      oe_reg <= !sel_sync_reg[1];                                    // [R9]
      if (state_reg == ST_SAMPLE) begin
        sdo_reg <= 1'b0;
      end else if (sclk_fall) begin
        if (state_reg == ST_NULL && bit_reg != `SAR_CNT_W'(`SAR_NULL_BITS - 1)) begin
          sdo_reg <= 1'b0;                                           // [R4]
        end else if (mask_reg != '0) begin
          sdo_reg <= cmp_i;                                          // [R5] [R4]
        end else begin
          sdo_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // finished results into the fifo; a full fifo drops the word and flags it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      push_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end else if (ce_i) begin
      push_reg <= sclk_fall && state_reg == ST_DATA &&
                  mask_reg == `SAR_RES_BITS'(1);
      ovr_reg  <= push_reg && !fifo_ready;
    end
  end

  sample_fifo #(
    .WIDTH (`SAR_RES_BITS),
    .DEPTH (`SAR_FIFO_DEPTH),
    .AW    (`SAR_FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_data_i   (res_reg),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_dout),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // registered output stage so the result port comes from flip-flops
  assign fifo_pop = fifo_valid && (!head_vld_reg || sample_ready_i);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      head_reg     <= '0;
      head_vld_reg <= 1'b0;
    end else if (ce_i) begin
      if (fifo_pop) begin
        head_reg     <= fifo_dout;
        head_vld_reg <= 1'b1;
      end else if (sample_ready_i) begin
        head_vld_reg <= 1'b0;
      end
    end
  end

  assign trial_o        = trial_reg;
  // one-hot sample bit of the state flip-flops
  assign track_o        = state_reg[0];
  assign sdo_o          = sdo_reg;
  assign sdo_oe_o       = oe_reg;
  assign sample_data_o  = head_reg;
  assign sample_valid_o = head_vld_reg;
  assign overrun_o      = ovr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  sample_only_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R3]
    (ce_i && $past(ce_i) && $past(sel_sync_reg[1])) |-> state_reg == ST_SAMPLE)
    else $error("frame left sampling while select high");

  frame_start_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
    (ce_i && state_reg == ST_SAMPLE && sel_fall && !sel_sync_reg[1]) |=>
      (!ce_i || sel_sync_reg[1] || state_reg == ST_NULL))
    else $error("falling select did not start a frame");

  output_release_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R9]
    (ce_i && sel_sync_reg[1]) |=> (!ce_i || !sdo_oe_o))
    else $error("output driven while select high");

  null_bits_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R4]
    (state_reg == ST_NULL) |-> !sdo_o)
    else $error("null bit not zero");

  sdo_edge_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
    (ce_i && $past(ce_i) && !$past(sclk_fall) && state_reg != ST_SAMPLE
     && $past(state_reg) != ST_SAMPLE) |-> $stable(sdo_o))
    else $error("output changed without falling shift edge");

  step_bit_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
    (ce_i && !sclk_fall && state_reg != ST_SAMPLE) |=> (!ce_i || $stable(mask_reg)))
    else $error("approximation step without shift edge");

  same_frame_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
    (ce_i && sclk_fall && state_reg == ST_DATA && mask_reg != '0 && !sel_sync_reg[1])
      |=> (!ce_i || sdo_o == ((res_reg & $past(mask_reg)) != '0)))
    else $error("output bit differs from current decision");

  fifo_full_a : assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && push_reg && !fifo_ready) |=> (!ce_i || overrun_o))
    else $error("dropped result not flagged");
endmodule

// File: dv/host_model.sv
// host-side model: frame select and shift clock, captures the serial word
`timescale 1ns/1ns

module host_model (
  output logic      sel_n_o,  // frame select, active low
  output logic      sclk_o,   // shift clock, idle low, still between frames
  input  wire logic sdo_i,    // serial data from the converter
  input  wire logic sdo_oe_i  // converter drives the data wire
);
  logic line;
  logic last;

  // no pull resistor on the wire: a released line shows the inverse of the last bit
  assign line = sdo_oe_i ? sdo_i : ~last;

  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    last    = 1'b0;
  end

  // 64 ns period, low phase kept long so the synchronised output has settled at the rise
  task automatic frame(input int rises, output logic [15:0] word);
    word = '0;
    #3 sel_n_o = 1'b0;
    for (int i = 0; i < rises; i++) begin
      #40 sclk_o = 1'b1;
      word = {word[14:0], line};
      last = line;
      #24 sclk_o = 1'b0;
    end
    #40 sel_n_o = 1'b1;
    #200;
  endtask
endmodule

// File: dv/testbench.sv
// self-checking bench: host frames, comparator model and result fifo traffic
`timescale 1ns/1ns

module testbench;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        sample_ready_i = 1'b0;
  logic        sel_n;
  logic        sclk;
  logic        cmp;
  logic [13:0] level = 14'h0000;
  logic [13:0] trial;
  logic [13:0] sample_data;
  logic        track;
  logic        sdo;
  logic        sdo_oe;
  logic        sample_valid;
  logic        overrun;
  logic [15:0] lfsr = 16'h0025;
  logic [13:0] exp_q[$];
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          overruns = 0;

  always #4 clk_i = ~clk_i;

  // comparator stand-in: input at or above the trial level
  assign cmp = (level >= trial);

  host_model i_host_model (
    .sel_n_o  (sel_n),
    .sclk_o   (sclk),
    .sdo_i    (sdo),
    .sdo_oe_i (sdo_oe)
  );

  sar_adc_serial_readout i_sar_adc_serial_readout (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .ce_i           (ce_i),
    .sel_n_i        (sel_n),
    .sclk_i         (sclk),
    .cmp_i          (cmp),
    .trial_o        (trial),
    .track_o        (track),
    .sdo_o          (sdo),
    .sdo_oe_o       (sdo_oe),
    .sample_data_o  (sample_data),
    .sample_valid_o (sample_valid),
    .sample_ready_i (sample_ready_i),
    .overrun_o      (overrun)
  );

  function automatic logic [15:0] next_rand(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction

  function automatic logic [15:0] frame_word(input logic [13:0] v);
    return {2'b00, v};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic run_frame(input logic [13:0] v, input bit keep);
    logic [15:0] w;
    @(posedge clk_i);
    level <= v;
    @(posedge clk_i);
    check({14'h0000, track, sdo_oe}, 16'h0002);
    if (keep) exp_q.push_back(v);
    i_host_model.frame(16, w);
    check(w, frame_word(v));
  endtask

  // result stream: every accepted word is the next finished conversion
  always @(posedge clk_i) begin
    cycles++;
    if (overrun === 1'b1) overruns++;
    if (!reset_i && sample_valid === 1'b1 && sample_ready_i) begin
      if (exp_q.size() == 0) check({2'b00, sample_data}, 16'hffff);
      else check({2'b00, sample_data}, {2'b00, exp_q.pop_front()});
    end
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    logic [15:0] w;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    sample_ready_i <= 1'b1;
    run_frame(14'h0000, 1'b1);
    run_frame(14'h3fff, 1'b1);
    run_frame(14'h2000, 1'b1);
    run_frame(14'h1fff, 1'b1);
    $display("corner codes done");
    @(posedge clk_i);
    level <= 14'h1555;
    i_host_model.frame(5, w);
    check(w, frame_word(14'h1555) >> 11);
    run_frame(14'h2aaa, 1'b1);
    $display("abort in mid-frame done");
    @(posedge clk_i);
    sample_ready_i <= 1'b0;
    // fifo plus output stage hold 33 words, the 34th result has nowhere to go
    for (int i = 0; i < 34; i++) begin
      lfsr = next_rand(lfsr);
      run_frame(lfsr[13:0], i < 33);
    end
    check(16'(overruns), 16'h0001);
    repeat (200) begin
      @(posedge clk_i);
      lfsr = next_rand(lfsr);
      sample_ready_i <= lfsr[0];
    end
    @(posedge clk_i);
    sample_ready_i <= 1'b1;
    repeat (80) @(posedge clk_i);
    check(16'(exp_q.size()), 16'h0000);
    $display("fifo fill and drain done");
    summarize();
  end
endmodule
